/* core/dpr_por.sv */
// dual rail power-on reset sequencer with bidirectional main reset line
`timescale 1ns/1ps
`default_nettype none
module dpr_por #(
  parameter logic [dpr_pkg::DPR_CNT_W-1:0] STRETCH_CYCLES =
    dpr_pkg::DPR_STRETCH_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // comparator results, high when the rail is above threshold
  input  wire logic standby_supply_ok,
  input  wire logic main_supply_ok,
  // standby reset output, active low
  output var  logic standby_reset_out_n,
  // main reset line, open drain, active low
  input  wire logic main_reset_line_in_n,
  output var  logic main_reset_line_out_n,
  output var  logic main_reset_line_oe_n,
  // outside party is pulling the main reset line low
  output var  logic ext_reset_req
);
  import dpr_pkg::*;

  typedef struct packed {
    logic [DPR_SYNC_LEN-1:0] sb_sync;
    logic [DPR_SYNC_LEN-1:0] mn_sync;
    logic [DPR_SYNC_LEN-1:0] ln_sync;
    logic                    sb_ok;
    logic                    mn_ok;
    logic                    ln_high;
    dpr_state_t              sb_state;
    dpr_state_t              mn_state;
    logic [DPR_CNT_W-1:0]    sb_cnt;
    logic [DPR_CNT_W-1:0]    mn_cnt;
    logic                    mn_first;
    logic                    sb_out_n;
    logic                    mn_oe_n;
    logic                    ext_req;
    logic [DPR_SYNC_LEN:0]   oe_hist;
  } dpr_regs_t;

  dpr_regs_t st;
  dpr_regs_t next_st;
  logic      rst_sync1;
  logic      rst_sync2;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // three-flop filter: value moves only when stages two and three agree
  function automatic logic filt(input logic [DPR_SYNC_LEN-1:0] s,
                                input logic old);
    filt = (s[1] == s[2]) ? s[2] : old;
  endfunction

  // next state of the whole block
  always_comb begin
    next_st = st;
    next_st.sb_sync = {st.sb_sync[1:0], standby_supply_ok};
    next_st.mn_sync = {st.mn_sync[1:0], main_supply_ok};
    next_st.ln_sync = {st.ln_sync[1:0], main_reset_line_in_n};
    next_st.sb_ok   = filt(st.sb_sync, st.sb_ok);
    next_st.mn_ok   = filt(st.mn_sync, st.mn_ok);
    next_st.ln_high = filt(st.ln_sync, st.ln_high);

    // standby rail sequencing
    case (st.sb_state)
      DPR_HOLD: begin
        next_st.sb_cnt = '0;
        if (st.sb_ok) begin
          next_st.sb_state = DPR_STRETCH;
        end
      end
      DPR_STRETCH: begin
        if (!st.sb_ok) begin
          next_st.sb_state = DPR_HOLD;
          next_st.sb_cnt   = '0;
        end else if (st.sb_cnt == STRETCH_CYCLES - 1'b1) begin
          next_st.sb_state = DPR_RUN;
        end else begin
          next_st.sb_cnt = st.sb_cnt + 1'b1;
        end
      end
      DPR_RUN: begin
        if (!st.sb_ok) begin
          next_st.sb_state = DPR_HOLD;
        end
      end
      default: begin
        next_st.sb_state = DPR_HOLD;
      end
    endcase
    // release only from the run state, so a low rail forces low
    next_st.sb_out_n = (next_st.sb_state == DPR_RUN);

    // main came up while standby was still low: main times itself
    if (!st.mn_ok) begin
      next_st.mn_first = 1'b0;
    end else if (st.mn_state == DPR_HOLD && !st.sb_ok) begin
      next_st.mn_first = 1'b1;
    end

    // main rail sequencing
    case (st.mn_state)
      DPR_HOLD: begin
        next_st.mn_cnt = '0;
        if (st.mn_ok) begin
          next_st.mn_state = DPR_STRETCH;
        end
      end
      DPR_STRETCH: begin
        if (!st.mn_ok) begin
          next_st.mn_state = DPR_HOLD;
          next_st.mn_cnt   = '0;
        end else if (!st.mn_first && !st.sb_out_n) begin
          // wait for standby release, then count the full stretch
          next_st.mn_cnt = '0;
        end else if (st.mn_cnt == STRETCH_CYCLES - 1'b1) begin
          next_st.mn_state = DPR_RUN;
        end else begin
          next_st.mn_cnt = st.mn_cnt + 1'b1;
        end
      end
      DPR_RUN: begin
        if (!st.mn_ok) begin
          next_st.mn_state = DPR_HOLD;
        end
      end
      default: begin
        next_st.mn_state = DPR_HOLD;
      end
    endcase
    next_st.mn_oe_n = (next_st.mn_state == DPR_RUN);

    // readback trails the filter by a few edges after release; wait
    // until the released line has had time to settle before trusting it
    next_st.oe_hist = {st.oe_hist[DPR_SYNC_LEN-1:0], st.mn_oe_n};
    next_st.ext_req = st.mn_oe_n && (&st.oe_hist) && !st.ln_high;
  end

  // single state register; all-zero reset asserts both resets
  always_ff @(posedge clk or negedge rst_sync2) begin
    if (!rst_sync2) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops, except the drive level, which is tied low
  assign standby_reset_out_n   = st.sb_out_n;
  assign main_reset_line_out_n = 1'b0; // open drain: only ever pulls low
  assign main_reset_line_oe_n  = st.mn_oe_n;
  assign ext_reset_req         = st.ext_req;

  // standby low rail forces standby reset on the next edge
  property p_sb_low;
    @(posedge clk) disable iff (!rst_sync2)
      !st.sb_ok |=> !standby_reset_out_n;
  endproperty
  a_sb_low: assert property (p_sb_low)
    else $error("standby reset not asserted with rail low");

  // standby release only after the counter has run the full stretch
  property p_sb_stretch;
    @(posedge clk) disable iff (!rst_sync2)
      $rose(standby_reset_out_n) |->
        $past(st.sb_cnt) == STRETCH_CYCLES - 1'b1 && $past(st.sb_ok);
  endproperty
  a_sb_stretch: assert property (p_sb_stretch)
    else $error("standby reset released before full stretch");

  // main low rail forces the line to be driven on the next edge
  property p_mn_low;
    @(posedge clk) disable iff (!rst_sync2)
      !st.mn_ok |=> !main_reset_line_oe_n && !main_reset_line_out_n;
  endproperty
  a_mn_low: assert property (p_mn_low)
    else $error("main reset not driven with rail low");

  // main release only after the full main stretch
  property p_mn_stretch;
    @(posedge clk) disable iff (!rst_sync2)
      $rose(main_reset_line_oe_n) |->
        $past(st.mn_cnt) == STRETCH_CYCLES - 1'b1 && $past(st.mn_ok);
  endproperty
  a_mn_stretch: assert property (p_mn_stretch)
    else $error("main reset released before full stretch");

  // main counter is idle while it waits on standby release
  property p_mn_wait;
    @(posedge clk) disable iff (!rst_sync2)
      (st.mn_state == DPR_STRETCH && !st.mn_first && !standby_reset_out_n
       && st.mn_ok) |=> st.mn_cnt == '0;
  endproperty
  a_mn_wait: assert property (p_mn_wait)
    else $error("main stretch counted before standby release");

  // an outside request is flagged only once the released line has settled
  property p_ext_req;
    @(posedge clk) disable iff (!rst_sync2)
      ext_reset_req |-> $past(main_reset_line_oe_n)
        && $past(main_reset_line_oe_n, 5) && !$past(st.ln_high);
  endproperty
  a_ext_req: assert property (p_ext_req)
    else $error("outside reset flagged while line driven or high");

  // a drop during stretch clears the count and keeps reset asserted
  property p_sb_restart;
    @(posedge clk) disable iff (!rst_sync2)
      (st.sb_state == DPR_STRETCH && !st.sb_ok) |=>
        st.sb_cnt == '0 && st.sb_state == DPR_HOLD && !standby_reset_out_n;
  endproperty
  a_sb_restart: assert property (p_sb_restart)
    else $error("standby stretch not restarted after drop");

  property p_mn_restart;
    @(posedge clk) disable iff (!rst_sync2)
      (st.mn_state == DPR_STRETCH && !st.mn_ok) |=>
        st.mn_cnt == '0 && st.mn_state == DPR_HOLD && !main_reset_line_oe_n;
  endproperty
  a_mn_restart: assert property (p_mn_restart)
    else $error("main stretch not restarted after drop");
endmodule
`default_nettype wire

/* include/dpr_pkg.sv */
// constants shared by the dual rail power-on reset block
package dpr_pkg;
  // clock rate and stretch time, figure kept as printed
  localparam logic [63:0] DPR_CLK_HZ     = 64'h0BEB_C200;
  localparam logic [63:0] DPR_STRETCH_MS = 64'h0000_00B4;
  localparam logic [63:0] DPR_MS_PER_S   = 64'h0000_03E8;
  // 180 ms at 200 MHz; sized 64 bits as the product passes 2**31
  localparam logic [63:0] DPR_STRETCH_CYC64 =
    (DPR_CLK_HZ * DPR_STRETCH_MS) / DPR_MS_PER_S;
  localparam int unsigned DPR_CNT_W = 32;
  localparam logic [DPR_CNT_W-1:0] DPR_STRETCH_CYC =
    DPR_STRETCH_CYC64[DPR_CNT_W-1:0];
  // input synchroniser depth
  localparam int unsigned DPR_SYNC_LEN = 3;
  // per-rail reset sequencing states
  typedef enum logic [1:0] {
    DPR_HOLD    = 2'b00,
    DPR_STRETCH = 2'b01,
    DPR_RUN     = 2'b10
  } dpr_state_t;
endpackage

/* testbench/dpr_far_end.sv */
// far-end model: pull-up on main reset wire plus outside pull
`timescale 1ns/1ps
`default_nettype none
module dpr_far_end (
  // device drive and outside request
  input  wire logic oe_n,
  input  wire logic pull_req,
  // resolved wire level
  output var  logic wire_n
);
  // pull-up wins only when nobody pulls low
  always_comb wire_n = oe_n && !pull_req;
endmodule
`default_nettype wire

/* testbench/dpr_por_tb_top.sv */
// testbench for the dual rail power-on reset sequencer
`timescale 1ns/1ps
`default_nettype none
module dpr_por_tb_top;
  localparam int N = 20;
  logic clk;
  logic rstn;
  logic sb_ok;
  logic mn_ok;
  logic pull;
  logic wire_n;
  logic sb_n;
  logic out_n;
  logic oe_n;
  logic ext_req;
  int   failures;
  int   checked;

  // short stretch so the run stays brief
  dpr_por #(.STRETCH_CYCLES(N)) dut (
    .clk(clk), .rstn(rstn), .standby_supply_ok(sb_ok),
    .main_supply_ok(mn_ok), .standby_reset_out_n(sb_n),
    .main_reset_line_in_n(wire_n), .main_reset_line_out_n(out_n),
    .main_reset_line_oe_n(oe_n), .ext_reset_req(ext_req));
  dpr_far_end far (.oe_n(oe_n), .pull_req(pull), .wire_n(wire_n));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // release must come no sooner than lo and before hi cycles
  task automatic rel(input bit m, input int lo, input int hi);
    int k;
    k = 0;
    while (k < hi && (m ? oe_n : sb_n) !== 1'b1) begin
      @(negedge clk);
      k++;
    end
    chk(m ? "main release" : "standby release", 1'b1, k >= lo && k < hi);
  endtask

  task automatic t_standby_first();
    tick(10);
    chk("standby low", 1'b0, sb_n);
    chk("main low", 1'b0, oe_n);
    chk("drive level", 1'b0, out_n);
    sb_ok = 1'b1;
    rel(0, N, N + 10);
    mn_ok = 1'b1;
    rel(1, N, N + 10);
    // readback of our own release must not look like an outside pull
    tick(3);
    chk("no false request", 1'b0, ext_req);
    $display("test standby_first done");
  endtask

  task automatic t_together();
    sb_ok = 1'b0;
    mn_ok = 1'b0;
    tick(6);
    chk("standby low", 1'b0, sb_n);
    chk("main low", 1'b0, oe_n);
    sb_ok = 1'b1;
    mn_ok = 1'b1;
    rel(0, N, N + 10);
    rel(1, N, N + 6);
    $display("test together done");
  endtask

  // rail dips in mid-stretch: full recount expected
  task automatic t_drop();
    mn_ok = 1'b0;
    tick(6);
    mn_ok = 1'b1;
    tick(N / 2 + 4);
    mn_ok = 1'b0;
    tick(6);
    chk("main reasserted", 1'b0, oe_n);
    mn_ok = 1'b1;
    rel(1, N, N + 10);
    $display("test drop done");
  endtask

  task automatic t_ext();
    pull = 1'b1;
    tick(8);
    chk("ext request", 1'b1, ext_req);
    pull = 1'b0;
    tick(8);
    chk("ext cleared", 1'b0, ext_req);
    $display("test ext done");
  endtask

  // main ahead of standby times itself; standby dip restarts standby only
  task automatic t_main_first();
    sb_ok = 1'b0;
    mn_ok = 1'b0;
    tick(6);
    mn_ok = 1'b1;
    rel(1, N, N + 10);
    chk("standby held", 1'b0, sb_n);
    sb_ok = 1'b1;
    tick(N / 2 + 4);
    sb_ok = 1'b0;
    tick(6);
    chk("standby reasserted", 1'b0, sb_n);
    sb_ok = 1'b1;
    rel(0, N, N + 10);
    chk("main kept", 1'b1, oe_n);
    $display("test main_first done");
  endtask

  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: tests need a few hundred cycles
  initial begin
    #20000;
    failures++;
    wrap_up();
  end

  initial begin
    failures = 0;
    checked = 0;
    rstn = 1'b0;
    sb_ok = 1'b0;
    mn_ok = 1'b0;
    pull = 1'b0;
    tick(3);
    rstn = 1'b1;
    t_standby_first();
    t_together();
    t_drop();
    t_ext();
    t_main_first();
    wrap_up();
  end
endmodule
`default_nettype wire
